// ===== dlbcs_pkg.sv
/*
 Shared constants and types of the display-list branch and call sequencer.
 Assumes one 20 MHz clock domain and a word-wide refresh memory port.
*/
package dlbcs_pkg;

   // Opcode field: first-word bits 15..6
   localparam logic [9:0]  OP_COND_ABS   = 10'h00a;
   localparam logic [9:0]  OP_COND_REL   = 10'h00b;
   localparam logic [9:0]  OP_JUMP_LINK  = 10'h010;
   localparam logic [9:0]  OP_ABS_CALL   = 10'h011;
   localparam logic [9:0]  OP_REL_CALL   = 10'h012;
   localparam logic [9:0]  OP_SUB_EXIT   = 10'h013;
   localparam int          OP_MSB        = 15;
   localparam int          OP_LSB        = 6;

   // Field positions
   localparam int          IND_BIT       = 15;
   localparam int          BANK_HI       = 15;
   localparam int          BANK_LO       = 14;

   // Address arithmetic
   localparam logic [15:0] WORD_STEP     = 16'h0002;
   localparam logic [15:0] BANK_STEP     = 16'h4000;
   localparam logic [15:0] EVEN_MASK     = 16'hfffe;
   localparam logic [15:0] DIRECT_MASK   = 16'h7ffe;

   // Reset values
   localparam logic [15:0] PC_RESET      = 16'h0000;
   localparam logic [15:0] SP_RESET      = 16'h0000;
   localparam logic [15:0] BANK_RESET    = 16'h0000;

   typedef enum logic [2:0] {
      K_NONE, K_CABS, K_CREL, K_JSL, K_CALL, K_RCALL, K_RET
   } dlbcs_kind_type;

   typedef struct packed {
      logic        req;
      logic        we;
      logic [17:0] addr;
      logic [15:0] wdata;
   } dlbcs_mem_req_type;

   typedef struct packed {
      logic        pc_we;
      logic        sp_we;
      logic        bank_we;
      logic [15:0] value;
   } dlbcs_arch_load_type;

endpackage

// ===== dlbcs_decode.sv
/*
 Opcode classifier for the sequence-control instructions.
 Assumes the first instruction word is presented as a stable level.
*/
`timescale 1ns/100ps
module dlbcs_decode
   import dlbcs_pkg::*;
(
   // Instruction word
   input  wire logic [15:0]    op_word_i,
   // Class
   output dlbcs_kind_type      kind_o
);

   always_comb begin
      case (op_word_i[OP_MSB:OP_LSB])
         OP_COND_ABS:  kind_o = K_CABS;
         OP_COND_REL:  kind_o = K_CREL;
         OP_JUMP_LINK: kind_o = K_JSL;
         OP_ABS_CALL:  kind_o = K_CALL;
         OP_REL_CALL:  kind_o = K_RCALL;
         OP_SUB_EXIT:  kind_o = K_RET;
         default:      kind_o = K_NONE;
      endcase
   end

endmodule

// ===== dlbcs_rel_adder.sv
/*
 Relative target adder with bank carry for extended addressing.
 Assumes a two's complement increment and a bank count in bank bits 15..14.
*/
`timescale 1ns/100ps
module dlbcs_rel_adder
   import dlbcs_pkg::*;
(
   // Operands
   input  wire logic [15:0] base_i,
   input  wire logic [15:0] inc_i,
   input  wire logic [15:0] bank_i,
   input  wire logic        ext_i,
   // Results
   output logic [15:0]      sum_o,
   output logic [15:0]      bank_o
);

   logic [16:0] wide;

   always_comb begin
      wide  = {1'b0, base_i} + {1'b0, inc_i};
      sum_o = wide[15:0];
      bank_o = bank_i;
      if (ext_i && !inc_i[15] && wide[16]) begin
         bank_o = bank_i + BANK_STEP;
      end else if (ext_i && inc_i[15] && !wide[16]) begin
         bank_o = bank_i - BANK_STEP;
      end
   end

endmodule

// ===== dlbcs_sequencer.sv
/*
 Sequence-control unit: conditional jumps, calls, return and jump-and-mark.
 Assumes the first word is handed over with the program counter already past
 it, and a refresh memory port that answers each request with a one-cycle ack.
*/
`timescale 1ns/100ps
module dlbcs_sequencer
   import dlbcs_pkg::*;
(
   // Clock and reset
   input  wire logic                clock_i,
   input  wire logic                rst_n_i,
   // Instruction hand-over
   input  wire logic                start_i,
   input  wire logic [15:0]         op_word_i,
   output logic                     ready_o,
   output logic                     done_o,
   output logic                     taken_o,
   output logic                     bad_op_o,
   // Machine state
   input  wire logic                extended_mode_bit_i,
   input  wire logic [15:0]         general_reg_zero_i,
   input  wire dlbcs_arch_load_type arch_load_i,
   output logic [15:0]              program_counter_o,
   output logic [15:0]              stack_pointer_o,
   output logic [15:0]              bank_register_o,
   // Refresh memory port
   output logic                     mem_req_o,
   output logic                     mem_we_o,
   output logic [17:0]              mem_addr_o,
   output logic [15:0]              mem_wdata_o,
   input  wire logic                mem_ack_i,
   input  wire logic [15:0]         mem_rdata_i
);

   typedef enum logic [3:0] {
      S_IDLE, S_FETCH, S_INDIR, S_PUSH_A, S_PUSH_B, S_POP_A, S_POP_B, S_APPLY, S_MARK
   } dlbcs_state_type;

   dlbcs_state_type   state_reg,  state_next;
   dlbcs_kind_type    kind_reg,   kind_next;
   dlbcs_kind_type    dec_kind;
   dlbcs_mem_req_type mreq_reg,   mreq_next;
   logic [15:0]       pc_reg,     pc_next;
   logic [15:0]       sp_reg,     sp_next;
   logic [15:0]       bank_reg,   bank_next;
   logic [15:0]       op1_reg,    op1_next;
   logic [15:0]       op2_reg,    op2_next;
   logic [15:0]       tgt_reg,    tgt_next;
   logic [1:0]        stk_reg,    stk_next;
   logic              ext_reg,    ext_next;
   logic              done_reg,   done_next;
   logic              taken_reg,  taken_next;
   logic              bad_reg,    bad_next;
   logic [15:0]       pc_adv;
   logic [15:0]       rel_sum;
   logic [15:0]       rel_bank;
   logic              reg0_set;

   function automatic dlbcs_mem_req_type mem_rd(input logic [1:0] bank,
                                                input logic [15:0] addr);
      dlbcs_mem_req_type r;
      r.req   = 1'b1;
      r.we    = 1'b0;
      r.addr  = {bank, addr & EVEN_MASK};
      r.wdata = 16'h0000;
      return r;
   endfunction

   function automatic dlbcs_mem_req_type mem_wr(input logic [1:0] bank,
                                                input logic [15:0] addr,
                                                input logic [15:0] data);
      dlbcs_mem_req_type r;
      r.req   = 1'b1;
      r.we    = 1'b1;
      r.addr  = {bank, addr & EVEN_MASK};
      r.wdata = data;
      return r;
   endfunction

   dlbcs_decode u_decode (
      .op_word_i (op_word_i),
      .kind_o    (dec_kind)
   );

   dlbcs_rel_adder u_adder (
      .base_i (pc_reg),
      .inc_i  (op2_reg),
      .bank_i (bank_reg),
      .ext_i  (ext_reg),
      .sum_o  (rel_sum),
      .bank_o (rel_bank)
   );

   assign pc_adv   = pc_reg + WORD_STEP;
   assign reg0_set = (general_reg_zero_i != 16'h0000);

   always_comb begin
      state_next = state_reg;
      kind_next  = kind_reg;
      mreq_next  = mreq_reg;
      pc_next    = pc_reg;
      sp_next    = sp_reg;
      bank_next  = bank_reg;
      op1_next   = op1_reg;
      op2_next   = op2_reg;
      tgt_next   = tgt_reg;
      stk_next   = stk_reg;
      ext_next   = ext_reg;
      done_next  = 1'b0;
      taken_next = 1'b0;
      bad_next   = 1'b0;
      case (state_reg)
         S_IDLE: begin
            if (arch_load_i.pc_we) begin
               pc_next = arch_load_i.value;
            end
            if (arch_load_i.sp_we) begin
               sp_next = arch_load_i.value;
            end
            if (arch_load_i.bank_we) begin
               bank_next = arch_load_i.value;
            end
            if (start_i) begin
               op1_next  = op_word_i;
               kind_next = dec_kind;
               stk_next  = bank_reg[BANK_HI:BANK_LO];
               ext_next  = extended_mode_bit_i;
               case (dec_kind)
                  K_NONE: begin
                     done_next = 1'b1;
                     bad_next  = 1'b1;
                  end
                  K_RET: begin
                     state_next = S_POP_A;
                     mreq_next  = mem_rd(bank_reg[BANK_HI:BANK_LO], sp_reg);
                  end
                  default: begin
                     state_next = S_FETCH;
                     mreq_next  = mem_rd(bank_reg[BANK_HI:BANK_LO], pc_reg);
                  end
               endcase
            end
         end
         S_FETCH: begin
            if (mem_ack_i) begin
               op2_next  = mem_rdata_i;
               pc_next   = pc_adv;
               mreq_next = '0;
               if (ext_reg) begin
                  tgt_next = mem_rdata_i;
               end else begin
                  tgt_next = mem_rdata_i & DIRECT_MASK;
               end
               case (kind_reg)
                  K_CABS, K_JSL: begin
                     if (kind_reg == K_CABS && !reg0_set) begin
                        state_next = S_IDLE;
                        done_next  = 1'b1;
                     end else if (!ext_reg && mem_rdata_i[IND_BIT]) begin
                        state_next = S_INDIR;
                        mreq_next  = mem_rd(bank_reg[BANK_HI:BANK_LO],
                                            mem_rdata_i & DIRECT_MASK);
                     end else begin
                        state_next = (kind_reg == K_JSL) ? S_MARK : S_APPLY;
                     end
                  end
                  K_CREL: begin
                     if (reg0_set) begin
                        state_next = S_APPLY;
                     end else begin
                        state_next = S_IDLE;
                        done_next  = 1'b1;
                     end
                  end
                  K_CALL: begin
                     tgt_next   = mem_rdata_i & EVEN_MASK;
                     state_next = S_PUSH_A;
                     sp_next    = sp_reg - WORD_STEP;
                     mreq_next  = mem_wr(stk_reg, sp_reg - WORD_STEP, pc_adv);
                  end
                  K_RCALL: begin
                     state_next = S_PUSH_A;
                     sp_next    = sp_reg - WORD_STEP;
                     mreq_next  = mem_wr(stk_reg, sp_reg - WORD_STEP,
                                         ext_reg ? bank_reg : pc_adv);
                  end
                  default: begin
                     state_next = S_IDLE;
                     done_next  = 1'b1;
                  end
               endcase
            end
         end
         S_INDIR: begin
            if (mem_ack_i) begin
               if (mem_rdata_i[IND_BIT]) begin
                  mreq_next = mem_rd(bank_reg[BANK_HI:BANK_LO],
                                     mem_rdata_i & DIRECT_MASK);
               end else begin
                  mreq_next  = '0;
                  tgt_next   = mem_rdata_i & DIRECT_MASK;
                  state_next = (kind_reg == K_JSL) ? S_MARK : S_APPLY;
               end
            end
         end
         S_PUSH_A: begin
            if (mem_ack_i) begin
               mreq_next = '0;
               if (ext_reg) begin
                  state_next = S_PUSH_B;
                  sp_next    = sp_reg - WORD_STEP;
                  mreq_next  = mem_wr(stk_reg, sp_reg - WORD_STEP,
                                      (kind_reg == K_CALL) ? bank_reg : pc_reg);
               end else begin
                  state_next = S_APPLY;
               end
            end
         end
         S_PUSH_B: begin
            if (mem_ack_i) begin
               mreq_next  = '0;
               state_next = S_APPLY;
            end
         end
         S_POP_A: begin
            if (mem_ack_i) begin
               sp_next = sp_reg + WORD_STEP;
               if (ext_reg) begin
                  bank_next  = mem_rdata_i;
                  state_next = S_POP_B;
                  mreq_next  = mem_rd(stk_reg, sp_reg + WORD_STEP);
               end else begin
                  pc_next    = mem_rdata_i;
                  mreq_next  = '0;
                  state_next = S_IDLE;
                  done_next  = 1'b1;
                  taken_next = 1'b1;
               end
            end
         end
         S_POP_B: begin
            if (mem_ack_i) begin
               pc_next    = mem_rdata_i;
               sp_next    = sp_reg + WORD_STEP;
               mreq_next  = '0;
               state_next = S_IDLE;
               done_next  = 1'b1;
               taken_next = 1'b1;
            end
         end
         S_APPLY: begin
            state_next = S_IDLE;
            done_next  = 1'b1;
            taken_next = 1'b1;
            case (kind_reg)
               K_CREL, K_RCALL: begin
                  pc_next   = rel_sum & EVEN_MASK;
                  bank_next = rel_bank;
               end
               K_CABS, K_CALL: begin
                  pc_next = tgt_reg;
                  if (ext_reg) begin
                     bank_next[BANK_HI:BANK_LO] = op1_reg[1:0];
                  end
               end
               default: begin
                  pc_next = pc_reg;
               end
            endcase
         end
         S_MARK: begin
            if (!mreq_reg.req) begin
               mreq_next = mem_wr(bank_reg[BANK_HI:BANK_LO], tgt_reg, pc_reg);
            end else if (mem_ack_i) begin
               mreq_next  = '0;
               pc_next    = tgt_reg + WORD_STEP;
               state_next = S_IDLE;
               done_next  = 1'b1;
               taken_next = 1'b1;
            end
         end
         default: begin
            state_next = S_IDLE;
            mreq_next  = '0;
         end
      endcase
   end

   // Sequencing state
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_reg <= S_IDLE;
         kind_reg  <= K_NONE;
         op1_reg   <= 16'h0000;
         op2_reg   <= 16'h0000;
         tgt_reg   <= 16'h0000;
         stk_reg   <= 2'h0;
         ext_reg   <= 1'b0;
      end else begin
         state_reg <= state_next;
         kind_reg  <= kind_next;
         op1_reg   <= op1_next;
         op2_reg   <= op2_next;
         tgt_reg   <= tgt_next;
         stk_reg   <= stk_next;
         ext_reg   <= ext_next;
      end
   end

   // Architectural registers
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         pc_reg   <= PC_RESET;
         sp_reg   <= SP_RESET;
         bank_reg <= BANK_RESET;
      end else begin
         pc_reg   <= pc_next;
         sp_reg   <= sp_next;
         bank_reg <= bank_next;
      end
   end

   // Memory port and status pulses
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         mreq_reg  <= '0;
         done_reg  <= 1'b0;
         taken_reg <= 1'b0;
         bad_reg   <= 1'b0;
      end else begin
         mreq_reg  <= mreq_next;
         done_reg  <= done_next;
         taken_reg <= taken_next;
         bad_reg   <= bad_next;
      end
   end

   assign ready_o           = (state_reg == S_IDLE);
   assign done_o            = done_reg;
   assign taken_o           = taken_reg;
   assign bad_op_o          = bad_reg;
   assign program_counter_o = pc_reg;
   assign stack_pointer_o   = sp_reg;
   assign bank_register_o   = bank_reg;
   assign mem_req_o         = mreq_reg.req;
   assign mem_we_o          = mreq_reg.we;
   assign mem_addr_o        = mreq_reg.addr;
   assign mem_wdata_o       = mreq_reg.wdata;

endmodule

// ===== dlbcs_mem_model.sv
/*
 Refresh memory model answering the sequencer's word requests.
 Assumes word addressing by address bits 17..1 and a one-cycle ack pulse.
*/
`timescale 1ns/100ps
module dlbcs_mem_model (
   // Clock
   input  wire logic        clock_i,
   // Request
   input  wire logic        mem_req_i,
   input  wire logic        mem_we_i,
   input  wire logic [17:0] mem_addr_i,
   input  wire logic [15:0] mem_wdata_i,
   // Pace
   input  wire logic        slow_i,
   // Answer
   output logic             mem_ack_o,
   output logic [15:0]      mem_rdata_o
);
   logic [15:0] mem [0:131071];
   logic [1:0]  wait_reg;

   initial begin
      mem_ack_o = 1'b0;
      mem_rdata_o = 16'h5a5a;
      wait_reg = 2'h0;
   end

   // Read data is only valid with ack; otherwise it toggles
   always @(posedge clock_i) begin
      if (mem_req_i && !mem_ack_o && (!slow_i || wait_reg == 2'h3)) begin
         mem_ack_o <= 1'b1;
         wait_reg <= 2'h0;
         if (mem_we_i) begin
            mem[mem_addr_i[17:1]] <= mem_wdata_i;
            mem_rdata_o <= ~mem_rdata_o;
         end else begin
            mem_rdata_o <= mem[mem_addr_i[17:1]];
         end
      end else begin
         mem_ack_o <= 1'b0;
         mem_rdata_o <= ~mem_rdata_o;
         if (mem_req_i && !mem_ack_o) begin
            wait_reg <= wait_reg + 2'h1;
         end
      end
   end
endmodule

// ===== dlbcs_seq_asserts.sv
/*
 Port-level checks for the branch and call sequencer.
 Assumes binding to dlbcs_sequencer in one clock domain.
*/
`timescale 1ns/100ps
module dlbcs_seq_asserts
   import dlbcs_pkg::*;
(
   // Clock and reset
   input wire logic                clock_i,
   input wire logic                rst_n_i,
   // Hand-over
   input wire logic                start_i,
   input wire logic [15:0]         op_word_i,
   input wire logic                ready_o,
   input wire logic                done_o,
   input wire logic                taken_o,
   input wire logic                bad_op_o,
   // Machine state
   input wire logic                extended_mode_bit_i,
   input wire logic [15:0]         general_reg_zero_i,
   input wire dlbcs_arch_load_type arch_load_i,
   input wire logic [15:0]         program_counter_o,
   input wire logic [15:0]         stack_pointer_o,
   input wire logic [15:0]         bank_register_o,
   // Memory port
   input wire logic                mem_req_o,
   input wire logic                mem_we_o,
   input wire logic [17:0]         mem_addr_o,
   input wire logic [15:0]         mem_wdata_o,
   input wire logic                mem_ack_i,
   input wire logic [15:0]         mem_rdata_i
);
   logic [15:0] op_reg, pc_reg, sp_reg, w2_reg, wa_reg;
   logic        ext_reg, got_reg;
   logic [9:0]  opc;

   assign opc = op_reg[OP_MSB:OP_LSB];

   // Latch the instruction context and its second word
   always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         op_reg <= 16'h0000;
         pc_reg <= 16'h0000;
         sp_reg <= 16'h0000;
         w2_reg <= 16'h0000;
         wa_reg <= 16'h0000;
         ext_reg <= 1'b0;
         got_reg <= 1'b0;
      end else if (start_i && ready_o) begin
         op_reg <= op_word_i;
         pc_reg <= program_counter_o;
         sp_reg <= stack_pointer_o;
         ext_reg <= extended_mode_bit_i;
         got_reg <= 1'b0;
      end else if (mem_req_o && mem_ack_i) begin
         if (!got_reg && !mem_we_o) begin
            w2_reg <= mem_rdata_i;
            got_reg <= 1'b1;
         end
         if (mem_we_o) begin
            wa_reg <= mem_addr_o[15:0];
         end
      end
   end

   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!rst_n_i);

   a_cond_zero: assert property (done_o && (opc == OP_COND_ABS || opc == OP_COND_REL) &&
      general_reg_zero_i == 16'h0000 |-> !taken_o && program_counter_o == pc_reg + WORD_STEP)
      else $error("conditional jump with zero register moved the counter");
   a_cond_taken: assert property (done_o && (opc == OP_COND_ABS || opc == OP_COND_REL) &&
      general_reg_zero_i != 16'h0000 |-> taken_o) else $error("conditional jump not taken");
   a_direct_target: assert property (done_o && opc == OP_COND_ABS && taken_o && !ext_reg &&
      !w2_reg[IND_BIT] |-> program_counter_o == (w2_reg & DIRECT_MASK))
      else $error("direct target wrong");
   a_ext_target: assert property (done_o && opc == OP_COND_ABS && taken_o && ext_reg |->
      program_counter_o == w2_reg && bank_register_o[BANK_HI:BANK_LO] == op_reg[1:0])
      else $error("extended jump target wrong");
   a_rel_sum: assert property (done_o && taken_o && (opc == OP_COND_REL || opc == OP_REL_CALL)
      |-> program_counter_o == pc_reg + WORD_STEP + w2_reg) else $error("relative sum wrong");
   a_call_depth: assert property (done_o && (opc == OP_ABS_CALL || opc == OP_REL_CALL) |->
      stack_pointer_o == sp_reg - (ext_reg ? 16'h0004 : WORD_STEP)) else $error("call depth wrong");
   a_exit_depth: assert property (done_o && opc == OP_SUB_EXIT |-> taken_o &&
      stack_pointer_o == sp_reg + (ext_reg ? 16'h0004 : WORD_STEP)) else $error("return depth wrong");
   a_mark_resume: assert property (done_o && opc == OP_JUMP_LINK |->
      program_counter_o == wa_reg + WORD_STEP) else $error("mark resume address wrong");
   a_access_hold: assert property (mem_req_o && !mem_ack_i |=> mem_req_o &&
      $stable(mem_addr_o) && mem_addr_o[0] == 1'b0) else $error("memory request not held");
   a_bad_quick: assert property (start_i && ready_o && op_word_i[15:6] == 10'h3f0 |->
      ##[1:2] done_o && bad_op_o && !taken_o) else $error("unhandled opcode not flagged");
endmodule

bind dlbcs_sequencer dlbcs_seq_asserts chk_u (
   .clock_i(clock_i), .rst_n_i(rst_n_i), .start_i(start_i), .op_word_i(op_word_i),
   .ready_o(ready_o), .done_o(done_o), .taken_o(taken_o), .bad_op_o(bad_op_o),
   .extended_mode_bit_i(extended_mode_bit_i), .general_reg_zero_i(general_reg_zero_i),
   .arch_load_i(arch_load_i), .program_counter_o(program_counter_o),
   .stack_pointer_o(stack_pointer_o), .bank_register_o(bank_register_o),
   .mem_req_o(mem_req_o), .mem_we_o(mem_we_o), .mem_addr_o(mem_addr_o),
   .mem_wdata_o(mem_wdata_o), .mem_ack_i(mem_ack_i), .mem_rdata_i(mem_rdata_i)
);

// ===== tb_display_list_branch_call_sequencer.sv
/*
 Self-checking bench for the branch and call sequencer.
 Assumes the memory model and checker are compiled alongside.
*/
`timescale 1ns/100ps
module tb_display_list_branch_call_sequencer;
   import dlbcs_pkg::*;

   // Flags: bank start 4000, extended, register nonzero, taken, bad
   typedef struct packed {
      logic [4:0]  fl;
      logic [15:0] op, pc0, w, a1, d1, a2, d2, epc, esp, ebk;
   } dlbcs_row_type;

   logic                clock_i = 1'b0;
   logic                rst_n_i = 1'b0;
   logic                start_i = 1'b0;
   logic [15:0]         op_word = 16'h0000;
   logic                ext_mode = 1'b0;
   logic [15:0]         gr0 = 16'h0000;
   dlbcs_arch_load_type arch_load = '0;
   logic                slow = 1'b0;
   logic                ready_o, done_o, taken_o, bad_op_o, mem_req_o, mem_we_o, mem_ack;
   logic [15:0]         program_counter_o, stack_pointer_o, bank_register_o;
   logic [15:0]         mem_wdata_o, mem_rdata;
   logic [17:0]         mem_addr_o;
   logic                tk, bd;
   int                  miscompares = 0;
   int                  total_checks = 0;

   dlbcs_row_type rows [16] = '{
   '{5'h06,16'h0280,16'h0100,16'h7fff,16'h0,16'h0,16'h0,16'h0,16'h7ffe,16'h1000,16'h0},
   '{5'h00,16'h0280,16'h0100,16'h1234,16'h0,16'h0,16'h0,16'h0,16'h0102,16'h1000,16'h0},
   '{5'h06,16'h0280,16'h0100,16'h8200,16'h0200,16'h8300,16'h0300,16'h0456,16'h0456,16'h1000,16'h0},
   '{5'h0e,16'h0282,16'h0100,16'h9000,16'h0,16'h0,16'h0,16'h0,16'h9000,16'h1000,16'h8000},
   '{5'h06,16'h02c0,16'h0100,16'h8000,16'h0,16'h0,16'h0,16'h0,16'h8102,16'h1000,16'h0},
   '{5'h00,16'h02c0,16'h0100,16'h0400,16'h0,16'h0,16'h0,16'h0,16'h0102,16'h1000,16'h0},
   '{5'h0e,16'h02c0,16'hfff0,16'h0020,16'h0,16'h0,16'h0,16'h0,16'h0012,16'h1000,16'h4000},
   '{5'h1e,16'h02c0,16'h0010,16'hff00,16'h0,16'h0,16'h0,16'h0,16'hff12,16'h1000,16'h0},
   '{5'h02,16'h0440,16'h0100,16'h2469,16'h0,16'h0,16'h0,16'h0,16'h2468,16'h0ffe,16'h0},
   '{5'h0a,16'h0443,16'h0100,16'hfffe,16'h0,16'h0,16'h0,16'h0,16'hfffe,16'h0ffc,16'hc000},
   '{5'h0a,16'h0480,16'hfff0,16'h0020,16'h0,16'h0,16'h0,16'h0,16'h0012,16'h0ffc,16'h4000},
   '{5'h02,16'h0480,16'h0100,16'h0010,16'h0,16'h0,16'h0,16'h0,16'h0112,16'h0ffe,16'h0},
   '{5'h02,16'h04c0,16'h0100,16'h0,16'h1000,16'h0abc,16'h0,16'h0,16'h0abc,16'h1002,16'h0},
   '{5'h0a,16'h04c0,16'h0100,16'h0,16'h1000,16'h8000,16'h1002,16'h0abc,16'h0abc,16'h1004,16'h8000},
   '{5'h02,16'h0400,16'h0100,16'h0600,16'h0,16'h0,16'h0,16'h0,16'h0602,16'h1000,16'h0},
   '{5'h01,16'hfc00,16'h0100,16'h0,16'h0,16'h0,16'h0,16'h0,16'h0100,16'h1000,16'h0}};

   always #25 clock_i = ~clock_i;

   dlbcs_sequencer dut_u (
      .clock_i(clock_i), .rst_n_i(rst_n_i), .start_i(start_i), .op_word_i(op_word),
      .ready_o(ready_o), .done_o(done_o), .taken_o(taken_o), .bad_op_o(bad_op_o),
      .extended_mode_bit_i(ext_mode), .general_reg_zero_i(gr0), .arch_load_i(arch_load),
      .program_counter_o(program_counter_o), .stack_pointer_o(stack_pointer_o),
      .bank_register_o(bank_register_o), .mem_req_o(mem_req_o), .mem_we_o(mem_we_o),
      .mem_addr_o(mem_addr_o), .mem_wdata_o(mem_wdata_o), .mem_ack_i(mem_ack),
      .mem_rdata_i(mem_rdata));

   dlbcs_mem_model mem_u (
      .clock_i(clock_i), .mem_req_i(mem_req_o), .mem_we_i(mem_we_o), .mem_addr_i(mem_addr_o),
      .mem_wdata_i(mem_wdata_o), .slow_i(slow), .mem_ack_o(mem_ack), .mem_rdata_o(mem_rdata));

   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("MISMATCH %s expected %h seen %h", name, exp, seen);
      end
   endtask

   task automatic conclude;
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic arch_set(input logic [15:0] pc, input logic [15:0] sp, input logic [15:0] bk);
      @(negedge clock_i) arch_load = '{1'b1, 1'b0, 1'b0, pc};
      @(negedge clock_i) arch_load = '{1'b0, 1'b1, 1'b0, sp};
      @(negedge clock_i) arch_load = '{1'b0, 1'b0, 1'b1, bk};
      @(negedge clock_i) arch_load = '0;
   endtask

   task automatic put(input logic [15:0] bk, input logic [15:0] a, input logic [15:0] d);
      if (a != 16'h0000) mem_u.mem[{bk[15:14], a[15:1]}] = d;
   endtask

   task automatic wait_done;
      int n;
      n = 0;
      while (done_o !== 1'b1 && n < 300) begin
         @(negedge clock_i);
         n++;
      end
      check("done", 16'(done_o), 16'h0001);
      tk = taken_o;
      bd = bad_op_o;
   endtask

   task automatic run(input logic [15:0] op, input logic now);
      if (!now) @(negedge clock_i);
      start_i = 1'b1;
      op_word = op;
      @(negedge clock_i);
      start_i = 1'b0;
      wait_done();
   endtask

   initial begin
      repeat (20) @(negedge clock_i);
      rst_n_i = 1'b1;
      check("ready", 16'(ready_o), 16'h0001);
      check("pc_reset", program_counter_o, PC_RESET);
      check("bank_reset", bank_register_o, BANK_RESET);
      foreach (rows[i]) begin
         arch_set(rows[i].pc0, 16'h1000, rows[i].fl[4] ? 16'h4000 : 16'h0000);
         ext_mode = rows[i].fl[3];
         gr0 = rows[i].fl[2] ? 16'h8000 : 16'h0000;
         put(bank_register_o, rows[i].pc0, rows[i].w);
         put(bank_register_o, rows[i].a1, rows[i].d1);
         put(bank_register_o, rows[i].a2, rows[i].d2);
         run(rows[i].op, 1'b0);
         check("pc", program_counter_o, rows[i].epc);
         check("sp", stack_pointer_o, rows[i].esp);
         check("bank", bank_register_o, rows[i].ebk);
         check("taken", 16'(tk), 16'(rows[i].fl[1]));
         check("bad", 16'(bd), 16'(rows[i].fl[0]));
      end
      check("mark_word", mem_u.mem[17'h00300], 16'h0102);
      // Slow memory, start and load while busy, return straight after call
      slow = 1'b1;
      arch_set(16'h0200, 16'h2000, 16'h4000);
      ext_mode = 1'b1;
      put(16'h4000, 16'h0200, 16'h3000);
      @(negedge clock_i);
      start_i = 1'b1;
      op_word = 16'h0441;
      @(negedge clock_i);
      op_word = 16'hfc00;
      arch_load = '{1'b1, 1'b0, 1'b0, 16'h5555};
      @(negedge clock_i);
      start_i = 1'b0;
      arch_load = '0;
      wait_done();
      check("busy_bad", 16'(bd), 16'h0000);
      check("call_pc", program_counter_o, 16'h3000);
      check("push_pc", mem_u.mem[{2'h1, 15'h0fff}], 16'h0202);
      check("push_bank", mem_u.mem[{2'h1, 15'h0ffe}], 16'h4000);
      run(16'h04c0, 1'b1);
      check("ret_pc", program_counter_o, 16'h0202);
      check("ret_sp", stack_pointer_o, 16'h2000);
      check("ret_bank", bank_register_o, 16'h4000);
      // Reset in mid-instruction
      @(negedge clock_i);
      start_i = 1'b1;
      op_word = 16'h0280;
      @(negedge clock_i);
      start_i = 1'b0;
      rst_n_i = 1'b0;
      @(negedge clock_i);
      check("rst_req", 16'(mem_req_o), 16'h0000);
      check("rst_pc", program_counter_o, PC_RESET);
      rst_n_i = 1'b1;
      @(negedge clock_i);
      check("rst_ready", 16'(ready_o), 16'h0001);
      conclude();
   end

   initial begin
      repeat (6000) @(posedge clock_i);
      miscompares++;
      conclude();
   end
endmodule
